// ===== core/jtidu_pkg.sv
/*
 * Package for the test access port: instruction codes, TAP states,
 * register widths, identification field layouts and pin chain length.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package jtidu_pkg;

   // Register widths
   localparam int IR_W  = 4;
   localparam int DR_W  = 32;
   localparam int BSR_W = 8;

   // Instruction codes
   localparam logic [3:0] INS_EXTEST   = 4'h0;
   localparam logic [3:0] INS_IDCODE   = 4'h1;
   localparam logic [3:0] INS_SAMPLE   = 4'h2;
   localparam logic [3:0] INS_USERCODE = 4'h3;
   localparam logic [3:0] INS_CHIP     = 4'h4;
   localparam logic [3:0] INS_FUSE     = 4'h5;
   localparam logic [3:0] INS_BYPASS   = 4'hf;

   // Value captured into the instruction shifter, low bits 01
   localparam logic [3:0] IR_CAPTURE   = 4'h1;

   // Identification word fields, values arbitrary
   localparam logic [3:0]  ID_VERSION  = 4'h0;
   localparam logic [15:0] ID_PART     = 16'h1234;
   localparam logic [10:0] ID_MAKER    = 11'h155;
   localparam logic [7:0]  SILICON_REV = 8'h01;

   // Usercode layout
   localparam int UC_ID_LSB  = 22;
   localparam int UC_REV_W   = 8;

   // Security register bits
   localparam int SEC_PORT_OFF = 0;
   localparam int SEC_FUSE_OFF = 13;
   localparam int SEC_UID_LSB  = 22;

   // Test clock rises in the five TMS-high reset walk
   localparam int RESET_TMS_EDGES = 5;

   // TAP states, Gray steps along the main scan path
   typedef enum logic [3:0] {
      ST_RESET   = 4'h0,
      ST_IDLE    = 4'h1,
      ST_SEL_DR  = 4'h3,
      ST_CAP_DR  = 4'h2,
      ST_SHF_DR  = 4'h6,
      ST_EX1_DR  = 4'h7,
      ST_PAU_DR  = 4'h5,
      ST_EX2_DR  = 4'h4,
      ST_UPD_DR  = 4'hc,
      ST_SEL_IR  = 4'hd,
      ST_CAP_IR  = 4'hf,
      ST_SHF_IR  = 4'he,
      ST_EX1_IR  = 4'ha,
      ST_PAU_IR  = 4'hb,
      ST_EX2_IR  = 4'h9,
      ST_UPD_IR  = 4'h8
   } jtidu_state_e;

endpackage : jtidu_pkg

// ===== core/jtidu_tap_if.sv
/*
 * Carrier between the port core and its state machine.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface jtidu_tap_if;
   logic                  step;    // One-cycle pulse on a test clock rise
   logic                  tms;     // Synchronised mode select
   logic                  off;     // Port disabled by security setting
   jtidu_pkg::jtidu_state_e state; // Current TAP state

   modport core (output step, output tms, output off, input state);
   modport fsm  (input step, input tms, input off, output state);
endinterface : jtidu_tap_if

// ===== core/jtidu_tap_fsm.sv
/*
 * Sixteen-state TAP controller, stepped once per test clock rise.
 * Assumes step and tms are already synchronised to i_clock.
 */
`timescale 1ns/100ps
module jtidu_tap_fsm
(
   input  wire logic   i_clock,
   input  wire logic   i_rst_n,
   jtidu_tap_if.fsm    tap
);
   jtidu_pkg::jtidu_state_e state_q;
   jtidu_pkg::jtidu_state_e state_d;
   logic [2:0]              ones_q;
   logic [2:0]              ones_d;

   // Next state; disabled port sits in reset
   always_comb
   begin
      state_d = state_q;
      ones_d  = ones_q;
      if (tap.off)
      begin
         state_d = jtidu_pkg::ST_RESET;
         ones_d  = 3'h0;
      end
      else if (tap.step)
      begin
         ones_d = tap.tms ? ((ones_q == 3'h7) ? ones_q : ones_q + 3'h1) : 3'h0;
         case (state_q)
            jtidu_pkg::ST_RESET:  state_d = tap.tms ? jtidu_pkg::ST_RESET  : jtidu_pkg::ST_IDLE;
            jtidu_pkg::ST_IDLE:   state_d = tap.tms ? jtidu_pkg::ST_SEL_DR : jtidu_pkg::ST_IDLE;
            jtidu_pkg::ST_SEL_DR: state_d = tap.tms ? jtidu_pkg::ST_SEL_IR : jtidu_pkg::ST_CAP_DR;
            jtidu_pkg::ST_CAP_DR: state_d = tap.tms ? jtidu_pkg::ST_EX1_DR : jtidu_pkg::ST_SHF_DR;
            jtidu_pkg::ST_SHF_DR: state_d = tap.tms ? jtidu_pkg::ST_EX1_DR : jtidu_pkg::ST_SHF_DR;
            jtidu_pkg::ST_EX1_DR: state_d = tap.tms ? jtidu_pkg::ST_UPD_DR : jtidu_pkg::ST_PAU_DR;
            jtidu_pkg::ST_PAU_DR: state_d = tap.tms ? jtidu_pkg::ST_EX2_DR : jtidu_pkg::ST_PAU_DR;
            jtidu_pkg::ST_EX2_DR: state_d = tap.tms ? jtidu_pkg::ST_UPD_DR : jtidu_pkg::ST_SHF_DR;
            jtidu_pkg::ST_UPD_DR: state_d = tap.tms ? jtidu_pkg::ST_SEL_DR : jtidu_pkg::ST_IDLE;
            jtidu_pkg::ST_SEL_IR: state_d = tap.tms ? jtidu_pkg::ST_RESET  : jtidu_pkg::ST_CAP_IR;
            jtidu_pkg::ST_CAP_IR: state_d = tap.tms ? jtidu_pkg::ST_EX1_IR : jtidu_pkg::ST_SHF_IR;
            jtidu_pkg::ST_SHF_IR: state_d = tap.tms ? jtidu_pkg::ST_EX1_IR : jtidu_pkg::ST_SHF_IR;
            jtidu_pkg::ST_EX1_IR: state_d = tap.tms ? jtidu_pkg::ST_UPD_IR : jtidu_pkg::ST_PAU_IR;
            jtidu_pkg::ST_PAU_IR: state_d = tap.tms ? jtidu_pkg::ST_EX2_IR : jtidu_pkg::ST_PAU_IR;
            jtidu_pkg::ST_EX2_IR: state_d = tap.tms ? jtidu_pkg::ST_UPD_IR : jtidu_pkg::ST_SHF_IR;
            jtidu_pkg::ST_UPD_IR: state_d = tap.tms ? jtidu_pkg::ST_SEL_DR : jtidu_pkg::ST_IDLE;
            default:              state_d = jtidu_pkg::ST_RESET;
         endcase
      end
   end

   // State register
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         state_q <= jtidu_pkg::ST_RESET;
         ones_q  <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         ones_q  <= ones_d;
      end
   end

   assign tap.state = state_q;

   // Five rises with TMS high always land in reset, from any state
   property p_five_ones;
      @(posedge i_clock) disable iff (!i_rst_n)
      (tap.step && tap.tms && ones_q == 3'h4) |=> (state_q == jtidu_pkg::ST_RESET);
   endproperty
   a_five_ones: assert property (p_five_ones) else $error("no reset after five TMS high");

   // No movement between test clock rises
   property p_hold;
      @(posedge i_clock) disable iff (!i_rst_n)
      (!tap.step && !tap.off) |=> $stable(state_q);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved without a clock rise");
endmodule : jtidu_tap_fsm

// ===== core/jtidu_port.sv
/*
 * Test access port core: oversampled test clock, instruction and data
 * shifters, identification and usercode words, pin scan chain, pass-through
 * to the chip-level TAP and to the fuse access path.
 * Assumes i_clock runs at least four times the test clock and that the
 * security word is static once loaded.
 */
`timescale 1ns/100ps
module jtidu_port
(
   input  wire logic                        i_clock,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_tck,
   input  wire logic                        i_tms,
   input  wire logic                        i_tdi,
   output logic                             o_tdo,
   output logic                             o_tdo_oe,
   input  wire logic [31:0]                 i_sec_word,
   input  wire logic [jtidu_pkg::BSR_W-1:0] i_pin_in,
   output logic      [jtidu_pkg::BSR_W-1:0] o_pin_out,
   output logic                             o_pin_take,
   output logic                             o_chip_tck,
   output logic                             o_chip_tms,
   output logic                             o_chip_tdi,
   input  wire logic                        i_chip_tdo,
   output logic                             o_fuse_tck,
   output logic                             o_fuse_tms,
   output logic                             o_fuse_tdi,
   input  wire logic                        i_fuse_tdo
);
   jtidu_tap_if tap ();

   logic [2:0] tck_s_q;
   logic [1:0] tms_s_q, tdi_s_q, ctdo_s_q, ftdo_s_q;
   logic       rise, fall, off, fuse_off;
   logic [3:0] ir_q, ir_d, irs_q, irs_d;
   logic [31:0] dr_q, dr_d;
   logic [jtidu_pkg::BSR_W-1:0] bsr_q, bsr_d;
   logic       tdo_q, tdo_d, oe_q, oe_d;
   logic [2:0] chip_q, chip_d, fuse_q, fuse_d;
   logic [31:0] id_word, uc_word;

   // Shift one bit in at the top of an active span, LSB leaves first
   function automatic logic [31:0] shift_in(input logic [31:0] v, input logic b,
                                            input int len);
      logic [31:0] r;
      r = v >> 1;
      r[len-1] = b;
      return r;
   endfunction : shift_in

   // Two-flop synchronisers; first stage feeds only the second
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         tck_s_q  <= 3'h0;
         tms_s_q  <= 2'h3;
         tdi_s_q  <= 2'h0;
         ctdo_s_q <= 2'h0;
         ftdo_s_q <= 2'h0;
      end
      else
      begin
         tck_s_q  <= {tck_s_q[1:0], i_tck};
         tms_s_q  <= {tms_s_q[0], i_tms};
         tdi_s_q  <= {tdi_s_q[0], i_tdi};
         ctdo_s_q <= {ctdo_s_q[0], i_chip_tdo};
         ftdo_s_q <= {ftdo_s_q[0], i_fuse_tdo};
      end
   end

   // Edges seen from stages two and three only
   assign rise     = tck_s_q[1] & ~tck_s_q[2];
   assign fall     = ~tck_s_q[1] & tck_s_q[2];
   assign off      = i_sec_word[jtidu_pkg::SEC_PORT_OFF];
   assign fuse_off = i_sec_word[jtidu_pkg::SEC_FUSE_OFF];

   assign tap.step = rise;
   assign tap.tms  = tms_s_q[1];
   assign tap.off  = off;

   jtidu_tap_fsm jtidu_tap_fsm_inst
   (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .tap     (tap)
   );

   // Fixed words; fixed 1 in bit 0, then maker code, then part, then version
   assign id_word = {jtidu_pkg::ID_VERSION, jtidu_pkg::ID_PART,
                     jtidu_pkg::ID_MAKER, 1'b1};
   // Fuse bits pass straight through, so a blank fuse reads zero
   assign uc_word = {i_sec_word[31:jtidu_pkg::SEC_UID_LSB],
                     {(jtidu_pkg::UC_ID_LSB-jtidu_pkg::UC_REV_W){1'b0}},
                     jtidu_pkg::SILICON_REV};

   // Instruction and data path next values
   always_comb
   begin
      ir_d   = ir_q;
      irs_d  = irs_q;
      dr_d   = dr_q;
      bsr_d  = bsr_q;
      tdo_d  = tdo_q;
      oe_d   = oe_q;
      chip_d = {chip_q[2], tms_s_q[1], tdi_s_q[1]};
      fuse_d = {fuse_q[2], tms_s_q[1], tdi_s_q[1]};
      chip_d[2] = (ir_q == jtidu_pkg::INS_CHIP) ? tck_s_q[1] : 1'b0;
      fuse_d[2] = (ir_q == jtidu_pkg::INS_FUSE) ? tck_s_q[1] : 1'b0;
      if (tap.state == jtidu_pkg::ST_RESET)
      begin
         ir_d = jtidu_pkg::INS_IDCODE;
         oe_d = 1'b0;
      end
      if (rise)
      begin
         case (tap.state)
            jtidu_pkg::ST_CAP_IR: irs_d = jtidu_pkg::IR_CAPTURE;
            jtidu_pkg::ST_SHF_IR: irs_d = {tdi_s_q[1], irs_q[3:1]};
            jtidu_pkg::ST_UPD_IR:
               ir_d = (irs_q == jtidu_pkg::INS_FUSE && fuse_off) ?
                      jtidu_pkg::INS_BYPASS : irs_q;
            jtidu_pkg::ST_CAP_DR:
               if (ir_q == jtidu_pkg::INS_IDCODE)
                  dr_d = id_word;
               else if (ir_q == jtidu_pkg::INS_USERCODE)
                  dr_d = uc_word;
               else if (ir_q == jtidu_pkg::INS_SAMPLE || ir_q == jtidu_pkg::INS_EXTEST)
                  dr_d = {{(32-jtidu_pkg::BSR_W){1'b0}}, i_pin_in};
               else
                  dr_d = 32'h0;
            jtidu_pkg::ST_SHF_DR:
               if (ir_q == jtidu_pkg::INS_IDCODE || ir_q == jtidu_pkg::INS_USERCODE)
                  dr_d = shift_in(dr_q, tdi_s_q[1], jtidu_pkg::DR_W);
               else if (ir_q == jtidu_pkg::INS_SAMPLE || ir_q == jtidu_pkg::INS_EXTEST)
                  dr_d = shift_in(dr_q, tdi_s_q[1], jtidu_pkg::BSR_W);
               else
                  dr_d = shift_in(dr_q, tdi_s_q[1], 1);
            jtidu_pkg::ST_UPD_DR:
               if (ir_q == jtidu_pkg::INS_SAMPLE || ir_q == jtidu_pkg::INS_EXTEST)
                  bsr_d = dr_q[jtidu_pkg::BSR_W-1:0];
            default: ;
         endcase
      end
      // TDO changes on the falling test clock, as the far end samples on rise
      if (fall)
      begin
         oe_d = (tap.state == jtidu_pkg::ST_SHF_IR) || (tap.state == jtidu_pkg::ST_SHF_DR);
         if (tap.state == jtidu_pkg::ST_SHF_IR)
            tdo_d = irs_q[0];
         else if (ir_q == jtidu_pkg::INS_CHIP)
            tdo_d = ctdo_s_q[1];
         else if (ir_q == jtidu_pkg::INS_FUSE)
            tdo_d = ftdo_s_q[1];
         else
            tdo_d = dr_q[0];
      end
      if (off)
      begin
         oe_d   = 1'b0;
         chip_d = 3'h0;
         fuse_d = 3'h0;
      end
   end

   // Path registers
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         ir_q   <= jtidu_pkg::INS_IDCODE;
         irs_q  <= 4'h0;
         dr_q   <= 32'h0;
         bsr_q  <= '0;
         tdo_q  <= 1'b0;
         oe_q   <= 1'b0;
         chip_q <= 3'h0;
         fuse_q <= 3'h0;
      end
      else
      begin
         ir_q   <= ir_d;
         irs_q  <= irs_d;
         dr_q   <= dr_d;
         bsr_q  <= bsr_d;
         tdo_q  <= tdo_d;
         oe_q   <= oe_d;
         chip_q <= chip_d;
         fuse_q <= fuse_d;
      end
   end

   assign o_tdo      = tdo_q;
   assign o_tdo_oe   = oe_q;
   assign o_pin_out  = bsr_q;
   assign o_pin_take = (ir_q == jtidu_pkg::INS_EXTEST) && !off;  // Pins follow chain
   assign o_chip_tck = chip_q[2];
   assign o_chip_tms = chip_q[1];
   assign o_chip_tdi = chip_q[0];
   assign o_fuse_tck = fuse_q[2];
   assign o_fuse_tms = fuse_q[1];
   assign o_fuse_tdi = fuse_q[0];

   // Disabled port never drives TDO nor the inner ports
   property p_off_quiet;
      @(posedge i_clock) disable iff (!i_rst_n)
      off |=> (!o_tdo_oe && !o_chip_tck && !o_fuse_tck);
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("port active while disabled");

   // Blocked fuse instruction never becomes current
   property p_fuse_block;
      @(posedge i_clock) disable iff (!i_rst_n)
      fuse_off |-> ##1 (ir_q != jtidu_pkg::INS_FUSE || $past(ir_q) == jtidu_pkg::INS_FUSE);
   endproperty
   a_fuse_block: assert property (p_fuse_block) else $error("fuse access while blocked");

   // Reset state selects identification
   property p_reset_id;
      @(posedge i_clock) disable iff (!i_rst_n)
      (tap.state == jtidu_pkg::ST_RESET) |=> (ir_q == jtidu_pkg::INS_IDCODE);
   endproperty
   a_reset_id: assert property (p_reset_id) else $error("reset did not select IDCODE");

   // Capture loads the identification word
   property p_cap_id;
      @(posedge i_clock) disable iff (!i_rst_n)
      (rise && tap.state == jtidu_pkg::ST_CAP_DR && ir_q == jtidu_pkg::INS_IDCODE)
         |=> (dr_q == id_word && dr_q[0] == 1'b1);
   endproperty
   a_cap_id: assert property (p_cap_id) else $error("IDCODE not captured");

   // Capture loads usercode with fuse bits on top and zero middle
   property p_cap_uc;
      @(posedge i_clock) disable iff (!i_rst_n)
      (rise && tap.state == jtidu_pkg::ST_CAP_DR && ir_q == jtidu_pkg::INS_USERCODE)
         |=> (dr_q[31:22] == i_sec_word[31:22] && dr_q[21:8] == 14'h0000);
   endproperty
   a_cap_uc: assert property (p_cap_uc) else $error("usercode capture wrong");

   // Usercode revision field in the low byte
   property p_uc_rev;
      @(posedge i_clock) disable iff (!i_rst_n)
      (rise && tap.state == jtidu_pkg::ST_CAP_DR && ir_q == jtidu_pkg::INS_USERCODE)
         |=> (dr_q[7:0] == jtidu_pkg::SILICON_REV);
   endproperty
   a_uc_rev: assert property (p_uc_rev) else $error("revision field wrong");

   // Data shifts one place right per rise, LSB out first
   property p_lsb_first;
      @(posedge i_clock) disable iff (!i_rst_n)
      (rise && tap.state == jtidu_pkg::ST_SHF_DR && ir_q == jtidu_pkg::INS_IDCODE)
         |=> (dr_q[30:0] == $past(dr_q[31:1]));
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("data not shifted LSB first");

   // Instruction shifter takes TDI at bit 3
   property p_ir_shift;
      @(posedge i_clock) disable iff (!i_rst_n)
      (rise && tap.state == jtidu_pkg::ST_SHF_IR) |=> (irs_q[3] == $past(tdi_s_q[1]));
   endproperty
   a_ir_shift: assert property (p_ir_shift) else $error("IR shift wrong");

   // Chip clock follows the test clock three cycles later when routed
   property p_chip_route;
      @(posedge i_clock) disable iff (!i_rst_n)
      (ir_q == jtidu_pkg::INS_CHIP && !off) |=> (o_chip_tck == $past(tck_s_q[1]));
   endproperty
   a_chip_route: assert property (p_chip_route) else $error("chip TAP not routed");
endmodule : jtidu_port

// ===== sim/jtidu_ctl_model.sv
/*
 * Behavioural model of the external test controller driving the port pins.
 * Assumes the port samples TCK with its own faster clock; TCK idles low
 * between steps and TDO is pulled up whenever the port releases it.
 */
`timescale 1ns/100ps
module jtidu_ctl_model
(
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   localparam realtime HALF = 24.0;
   logic tdo_w;

   // Released TDO floats up to the pull-up level
   assign tdo_w = i_tdo_oe ? i_tdo : 1'b1;

   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end

   // One test clock; TDO read late in the high phase for sync margin
   task automatic step(input logic tms, input logic tdi, output logic tdo);
   begin
      o_tms = tms;
      o_tdi = tdi;
      #(HALF);
      o_tck = 1'b1;
      #(HALF - 1.0);
      tdo = tdo_w;
      #(1.0);
      o_tck = 1'b0;
   end
   endtask : step

   // Walk n steps with TMS taken LSB first
   task automatic walk(input logic [7:0] tmsv, input int n);
      logic b;
   begin
      for (int i = 0; i < n; i++)
         step(tmsv[i], 1'b0, b);
   end
   endtask : walk

   // Full scan from Idle: select, shift n bits LSB first, update, Idle
   task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic b;
   begin
      dout = '1;
      if (is_ir)
         walk(8'h03, 4);
      else
         walk(8'h01, 3);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      walk(8'h01, 2);
   end
   endtask : scan

   // Five TMS-high clocks, then settle in Idle
   task automatic tap_reset();
   begin
      walk(8'h1f, 5);
      walk(8'h00, 1);
   end
   endtask : tap_reset
endmodule : jtidu_ctl_model

// ===== sim/jtidu_port_test.sv
/*
 * Self-checking bench for the test access port: identification, usercode,
 * pin scan, bypass, chip and fuse pass-through, port disable, TMS reset.
 * Assumes the controller model above and a 200 MHz system clock.
 */
`timescale 1ns/100ps
module jtidu_port_test;
   logic        i_clock;
   logic        i_rst_n;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        o_tdo;
   logic        o_tdo_oe;
   logic [31:0] i_sec_word;
   logic [7:0]  i_pin_in;
   logic [7:0]  o_pin_out;
   logic        o_pin_take;
   logic        o_chip_tck;
   logic        o_chip_tms;
   logic        o_chip_tdi;
   logic        i_chip_tdo;
   logic        o_fuse_tck;
   logic        o_fuse_tms;
   logic        o_fuse_tdi;
   logic        i_fuse_tdo;
   logic        chip_q = 1'b0;
   logic        fuse_q = 1'b0;
   logic        oe_seen;
   logic [31:0] d;
   logic [31:0] p;
   int          fuse_rises;
   int          fail_count = 0;
   int          checks_done = 0;
   int          seed = 28239;

   jtidu_port jtidu_port_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_tck(tck),
      .i_tms(tms), .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
      .i_sec_word(i_sec_word), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
      .o_pin_take(o_pin_take), .o_chip_tck(o_chip_tck), .o_chip_tms(o_chip_tms),
      .o_chip_tdi(o_chip_tdi), .i_chip_tdo(i_chip_tdo), .o_fuse_tck(o_fuse_tck),
      .o_fuse_tms(o_fuse_tms), .o_fuse_tdi(o_fuse_tdi), .i_fuse_tdo(i_fuse_tdo));

   jtidu_ctl_model jtidu_ctl_model_inst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
      .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));

   // System clock
   initial i_clock = 1'b0;
   always #2.5 i_clock = ~i_clock;

   // Far-side stand-ins: one inverting stage each, so a stuck path shows
   always @(posedge o_chip_tck) chip_q <= o_chip_tdi;
   always @(posedge o_fuse_tck) fuse_q <= o_fuse_tdi;
   always @(posedge o_fuse_tck) fuse_rises <= fuse_rises + 1;
   always @(negedge i_clock) i_chip_tdo <= ~chip_q;
   always @(negedge i_clock) i_fuse_tdo <= ~fuse_q;
   always @(posedge i_clock) if (o_tdo_oe === 1'b1) oe_seen <= 1'b1;

   function automatic logic [31:0] id_exp();
      return {jtidu_pkg::ID_VERSION, jtidu_pkg::ID_PART, jtidu_pkg::ID_MAKER, 1'b1};
   endfunction : id_exp

   function automatic logic [31:0] uc_exp(input logic [31:0] sec);
      return {sec[31:22], 14'h0, jtidu_pkg::SILICON_REV};
   endfunction : uc_exp

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
   begin
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
   begin
      chk_word({31'h0, got}, {31'h0, exp});
   end
   endtask : chk_bit

   // Reset with a new security word, which is static once loaded
   task automatic do_reset(input logic [31:0] sec, input int hold);
   begin
      @(negedge i_clock);
      i_rst_n <= 1'b0;
      i_sec_word <= sec;
      repeat (hold) @(negedge i_clock);
      i_rst_n <= 1'b1;
      repeat (4) @(negedge i_clock);
      // Reset leaves the TAP in reset; every scan expects to start in Idle
      jtidu_ctl_model_inst.walk(8'h00, 1);
   end
   endtask : do_reset

   task automatic load_ir(input logic [3:0] code);
   begin
      jtidu_ctl_model_inst.scan(1'b1, 4, {28'h0, code}, d);
      chk_word({28'h0, d[3:0]}, {28'h0, jtidu_pkg::IR_CAPTURE});
   end
   endtask : load_ir

   task automatic final_report();
   begin
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask : final_report

   // Main sequence
   initial
   begin
      i_rst_n = 1'b0;
      i_sec_word = 32'h0;
      i_pin_in = 8'h0;
      i_chip_tdo = 1'b0;
      i_fuse_tdo = 1'b0;
      oe_seen = 1'b0;
      fuse_rises = 0;
      do_reset(32'h0, 16);
      // Default instruction straight after reset
      jtidu_ctl_model_inst.scan(1'b0, 32, 32'h0, d);
      chk_word(d, id_exp());
      chk_bit(oe_seen, 1'b1);
      load_ir(jtidu_pkg::INS_USERCODE);
      jtidu_ctl_model_inst.scan(1'b0, 32, 32'h0, d);
      chk_word(d, uc_exp(32'h0));
      // Random user ID fields, port kept on
      for (int k = 0; k < 3; k++)
      begin
         p = $random(seed);
         p[0] = 1'b0;
         do_reset(p, 4);
         load_ir(jtidu_pkg::INS_USERCODE);
         jtidu_ctl_model_inst.scan(1'b0, 32, 32'h0, d);
         chk_word(d, uc_exp(p));
      end
      // Abort a shift midway with the TMS-high walk
      jtidu_ctl_model_inst.walk(8'h01, 3);
      jtidu_ctl_model_inst.walk(8'h00, 5);
      jtidu_ctl_model_inst.tap_reset();
      jtidu_ctl_model_inst.scan(1'b0, 32, 32'h0, d);
      chk_word(d, id_exp());
      // Pin chain capture and update
      @(negedge i_clock);
      i_pin_in <= 8'($random(seed));
      p = $random(seed);
      load_ir(jtidu_pkg::INS_SAMPLE);
      jtidu_ctl_model_inst.scan(1'b0, 8, p, d);
      chk_word({24'h0, d[7:0]}, {24'h0, i_pin_in});
      chk_word({24'h0, o_pin_out}, {24'h0, p[7:0]});
      chk_bit(o_pin_take, 1'b0);
      load_ir(jtidu_pkg::INS_EXTEST);
      chk_bit(o_pin_take, 1'b1);
      // Bypass is one stage, capturing zero
      load_ir(jtidu_pkg::INS_BYPASS);
      chk_bit(o_pin_take, 1'b0);
      jtidu_ctl_model_inst.scan(1'b0, 8, p, d);
      chk_word({24'h0, d[7:0]}, {24'h0, p[6:0], 1'b0});
      // Chip TAP pass-through
      load_ir(jtidu_pkg::INS_CHIP);
      jtidu_ctl_model_inst.scan(1'b0, 8, p, d);
      chk_word({24'h0, d[7:0]}, {24'h0, ~{p[6:0], 1'b0}});
      jtidu_ctl_model_inst.walk(8'h01, 1);
      chk_bit(o_chip_tms, 1'b1);
      // Fuse path open, then blocked by its security bit
      for (int k = 0; k < 2; k++)
      begin
         do_reset({18'h0, k[0], 13'h0}, 4);
         fuse_rises = 0;
         load_ir(jtidu_pkg::INS_FUSE);
         jtidu_ctl_model_inst.scan(1'b0, 8, p, d);
         if (k == 0)
            chk_word({24'h0, d[7:0]}, {24'h0, ~{p[6:0], 1'b0}});
         else
            chk_word({24'h0, d[7:0]}, {24'h0, p[6:0], 1'b0});
         chk_bit(fuse_rises == 0, k[0]);
         jtidu_ctl_model_inst.walk(8'h01, 1);
         if (k == 0)
            chk_bit(o_fuse_tms, 1'b1);
      end
      // Port disabled: TDO never driven, identity never seen
      do_reset(32'h1, 4);
      oe_seen = 1'b0;
      // Released TDO shows the pull-up even at IR capture
      jtidu_ctl_model_inst.scan(1'b1, 4, {28'h0, jtidu_pkg::INS_USERCODE}, d);
      chk_word({28'h0, d[3:0]}, 32'hf);
      jtidu_ctl_model_inst.scan(1'b0, 32, 32'h0, d);
      chk_word(d, 32'hffffffff);
      chk_bit(oe_seen, 1'b0);
      final_report();
   end

   // Watchdog, well beyond the expected run of about 22 us
   initial
   begin
      #300000;
      fail_count++;
      final_report();
   end
endmodule : jtidu_port_test
